//--- bench/tb_top.sv
`timescale 1ns/1ns
// Drives both ends' user sides and checks each translation outcome.
module tb_top;
  logic clk, rst_n, avs_rd, avs_wr, wr_en, req_valid, req_write, gpa_seen;
  logic avs_wait, req_ready, rsp_valid, zero_o, drop_o, irq, r_zero, r_drop;
  logic [3:0] avs_a;
  logic [31:0] avs_wd, avs_rdata, rd;
  logic [9:0] wr_idx;
  logic [63:0] wr_data;
  logic [47:0] req_addr, rsp_addr, r_addr;
  logic [1:0] rsp_res, r_res;
  int miscompares = 0;
  int tests_run = 0;
  // Level indices 1, 2, 4 and tile offset beef.
  localparam logic [47:0] VA = 48'h0008_0804_beef;
  trw_if link();
  trw_walker trw_walker_inst (.REF_CLK_I(clk), .RESET_N_I(rst_n), .LINK(link),
    .AVS_READ_I(avs_rd), .AVS_WRITE_I(avs_wr), .AVS_ADDRESS_I(avs_a),
    .AVS_WRITEDATA_I(avs_wd), .AVS_READDATA_O(avs_rdata), .AVS_WAITREQUEST_O(avs_wait),
    .REQ_VALID_I(req_valid), .REQ_WRITE_I(req_write), .REQ_ADDR_I(req_addr),
    .REQ_READY_O(req_ready), .RSP_VALID_O(rsp_valid), .RSP_ADDR_O(rsp_addr),
    .RSP_RESULT_O(rsp_res), .RSP_ZERO_DATA_O(zero_o), .RSP_DROP_WRITE_O(drop_o), .IRQ_O(irq));
  trw_table_mem trw_table_mem_inst (.REF_CLK_I(clk), .RESET_N_I(rst_n), .LINK(link),
    .WR_EN_I(wr_en), .WR_IDX_I(wr_idx), .WR_DATA_I(wr_data));
  trw_chk trw_chk_inst (.REF_CLK_I(clk), .RESET_N_I(rst_n), .fetch_req(link.fetch_req),
    .fetch_addr(link.fetch_addr), .fetch_kind(link.fetch_kind), .fetch_ack(link.fetch_ack),
    .fetch_data(link.fetch_data));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Keeps the address mode of the latest table fetch.
  always @(posedge clk)
    if (link.fetch_req)
      gpa_seen <= link.fetch_gpa;
  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Avalon access; each task starts on a fresh edge so no signal is set twice in a step.
  // It waits as long as waitrequest stands; only the watchdog ends a hung access.
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_rd <= !w;
    avs_wr <= w;
    avs_a <= a;
    avs_wd <= d;
    do
    begin
      @(posedge clk);
    end while (avs_wait);
    rd = avs_rdata;
    avs_rd <= 1'b0;
    avs_wr <= 1'b0;
  endtask
  task automatic ld(input logic [9:0] i, input logic [63:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_idx <= i;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // One client access; the reply is sampled at the edge that ends its pulse cycle.
  task automatic xl(input logic w, input logic [47:0] a);
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    do
    begin
      @(posedge clk);
    end while (!req_ready);
    req_valid <= 1'b0;
    do
    begin
      @(posedge clk);
    end while (!rsp_valid);
    r_addr = rsp_addr;
    r_res = rsp_res;
    r_zero = zero_o;
    r_drop = drop_o;
  endtask
  task report_and_stop;
    $display("Counts: tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Cuts a hang short well after the sequence should end.
  initial
  begin
    repeat (3000) @(posedge clk);
    miscompares++;
    report_and_stop;
  end
  initial
  begin
    {rst_n, avs_rd, avs_wr, wr_en, req_valid, req_write} <= '0;
    {avs_a, avs_wd, wr_idx, wr_data, req_addr} <= '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    av(1'b0, trw_pkg::REG_CTRL, '0);
    chk("ctrl", 48'(trw_pkg::CTRL_RST), 48'(rd));
    xl(1'b0, VA);
    chk("bypass", VA, r_addr);
    chk("bypass res", 48'(trw_pkg::TRW_RES_REMAP), 48'(r_res));
    av(1'b0, 4'h1, '0);
    chk("unmapped", '0, 48'(rd));
    // Ignored entry bits are set on purpose.
    ld(10'h001, 64'habcd_0000_0000_1ffc);
    ld(10'h202, 64'hffff_0000_0000_2ffc);
    // Halves differ so that a wrong half pick of the first-level word shows up.
    ld(10'h002, 64'h9abc_def0_1234_5678);
    av(1'b1, trw_pkg::REG_L3_LO, '0);
    av(1'b1, trw_pkg::REG_L3_HI, 32'h0000_0001);
    av(1'b0, trw_pkg::REG_L3_HI, '0);
    chk("l3 hi", 48'h1, 48'(rd));
    for (int m = 0; m < 2; m++)
    begin
      av(1'b1, trw_pkg::REG_CTRL, 32'(m * 2));
      xl(1'b0, VA);
      chk("remap", 48'h1234_5678_beef, r_addr);
      chk("remap res", 48'(trw_pkg::TRW_RES_REMAP), 48'(r_res));
      chk("gpa", 48'(m), 48'(gpa_seen));
    end
    // Odd first-level index: the entry sits in the upper half of the word.
    xl(1'b0, VA | 48'h0000_0001_0000);
    chk("remap odd", 48'h9abc_def0_beef, r_addr);
    ld(10'h202, 64'hffff_0000_0000_2ffe);
    for (int w = 0; w < 2; w++)
    begin
      xl(w[0], VA);
      chk("null res", 48'(trw_pkg::TRW_RES_NULL), 48'(r_res));
      chk("null zero", 48'h1, 48'(r_zero));
      chk("null drop", 48'(w), 48'(r_drop));
    end
    chk("irq masked", '0, 48'(irq));
    av(1'b1, trw_pkg::REG_STAT, 32'h0001_0003);
    ld(10'h001, 64'h0000_0000_0000_1001);
    xl(1'b1, VA);
    chk("inv res", 48'(trw_pkg::TRW_RES_INVALID), 48'(r_res));
    chk("inv drop", 48'h1, 48'(r_drop));
    chk("inv zero", 48'h1, 48'(r_zero));
    av(1'b0, trw_pkg::REG_STAT, '0);
    chk("status", 48'h1_0001, 48'(rd));
    chk("irq", 48'h1, 48'(irq));
    av(1'b1, trw_pkg::REG_STAT, 32'h0001_0001);
    @(posedge clk);
    chk("irq clr", '0, 48'(irq));
    report_and_stop;
  end
endmodule

//--- bench/trw_chk.sv
`timescale 1ns/1ns
// Watches the fetch link between the walker and the table store.
module trw_chk (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic fetch_req,
  input wire logic [47:0] fetch_addr,
  input wire logic [1:0] fetch_kind,
  input wire logic fetch_ack,
  input wire logic [63:0] fetch_data
);
  // Last entry returned; the next level's base must come from it.
  logic [63:0] ent_r;
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    if (!RESET_N_I)
      ent_r <= '0;
    else if (fetch_ack)
      ent_r <= fetch_data;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  a_ack_follows: assert property ($rose(fetch_req) |=> fetch_ack)
    else $error("fetch not answered");
  a_ack_pulse: assert property (fetch_ack |=> !fetch_ack)
    else $error("ack longer than one cycle");
  a_req_hold: assert property ($rose(fetch_req) |=> $stable(fetch_addr) && $stable(fetch_kind))
    else $error("fetch changed before ack");
  a_kind_legal: assert property (fetch_req |-> fetch_kind != 2'b11)
    else $error("unknown fetch kind");
  a_entry_align: assert property (fetch_req |-> (fetch_kind == trw_pkg::FETCH_L1 ?
    fetch_addr[1:0] == 2'b00 : fetch_addr[2:0] == 3'b000))
    else $error("entry address misaligned");
  a_next_base: assert property (fetch_req && fetch_kind != trw_pkg::FETCH_L3
    |-> fetch_addr[47:12] == ent_r[47:12])
    else $error("next level base wrong");
  a_l2_follows: assert property (fetch_ack && fetch_kind == trw_pkg::FETCH_L3 &&
    fetch_data[1:0] == 2'b00 |=> ##[0:2] fetch_req && fetch_kind == trw_pkg::FETCH_L2)
    else $error("walk did not descend");
  a_stop_early: assert property (fetch_ack && fetch_kind != trw_pkg::FETCH_L1 &&
    fetch_data[1:0] != 2'b00 |=> !(fetch_req && fetch_kind != trw_pkg::FETCH_L3) [*3])
    else $error("walk went on past a stop entry");
  c_l1: cover property (fetch_req && fetch_kind == trw_pkg::FETCH_L1);
  c_inv: cover property (fetch_ack && fetch_data[0] && fetch_kind == trw_pkg::FETCH_L3);
  c_null: cover property (fetch_ack && fetch_data[1] && fetch_kind == trw_pkg::FETCH_L2);
endmodule

//--- verilog/trw_if.sv
`timescale 1ns/1ns
// Link between the translation walker and the table memory agent.
interface trw_if;
  logic fetch_req;
  logic [47:0] fetch_addr;
  logic [1:0] fetch_kind;
  logic fetch_gpa;
  logic fetch_ack;
  logic [63:0] fetch_data;
  modport walker (output fetch_req, output fetch_addr, output fetch_kind, output fetch_gpa,
    input fetch_ack, input fetch_data);
  modport tables (input fetch_req, input fetch_addr, input fetch_kind, input fetch_gpa,
    output fetch_ack, output fetch_data);
endinterface

//--- verilog/trw_pkg.sv
package trw_pkg;
  // Address geometry of the tile remap walk.
  localparam int VA_W = 48;
  localparam int TILE_OFS_W = 16;
  localparam int L3_IDX_HI = 43;
  localparam int L3_IDX_LO = 35;
  localparam int L2_IDX_HI = 34;
  localparam int L2_IDX_LO = 26;
  localparam int L1_IDX_HI = 25;
  localparam int L1_IDX_LO = 16;
  localparam int BASE_HI = 47;
  localparam int BASE_LO = 12;
  localparam int NULL_BIT = 1;
  localparam int INV_BIT = 0;
  localparam int L3_ENTRIES = 512;
  localparam int L2_ENTRIES = 512;
  localparam int L1_ENTRIES = 1024;
  localparam int PAGE_BYTES = 4096;
  localparam int L32_ENTRY_BYTES = 8;
  localparam int L1_ENTRY_BYTES = 4;
  // Register offsets of the control block, byte addresses.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_L3_LO = 4'h4;
  localparam logic [3:0] REG_L3_HI = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hc;
  // Control bit positions.
  localparam int CTRL_BYPASS = 0;
  localparam int CTRL_GPA_MODE = 1;
  // Status bit positions: invalid tile seen, null tile seen.
  localparam int ST_INV = 0;
  localparam int ST_NULL = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  // Result codes of a translation.
  typedef enum logic [1:0] {
    TRW_RES_REMAP = 2'b00,
    TRW_RES_NULL = 2'b01,
    TRW_RES_INVALID = 2'b10
  } trw_res_e;
  // Table memory fetch kinds.
  localparam logic [1:0] FETCH_L3 = 2'b00;
  localparam logic [1:0] FETCH_L2 = 2'b01;
  localparam logic [1:0] FETCH_L1 = 2'b10;
endpackage

//--- verilog/trw_table_mem.sv
`timescale 1ns/1ns
// Memory-resident table side: answers each fetch from a small local store.
module trw_table_mem #(
  parameter int DEPTH = 1024
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  trw_if.tables LINK,
  input wire logic WR_EN_I,
  input wire logic [9:0] WR_IDX_I,
  input wire logic [63:0] WR_DATA_I
);
  // All state but the table words as one packed struct.
  typedef struct packed {
    logic ack;
    logic [63:0] data;
  } trw_mem_s;
  trw_mem_s st_r;
  trw_mem_s st_nxt;
  // Table words, indexed by the word address of the fetch.
  logic [63:0] mem [DEPTH];
  // Table pages are loaded by the user side; each level is one 4KB page.
  always_ff @(posedge REF_CLK_I)
  begin
    if (WR_EN_I)
    begin
      mem[WR_IDX_I] <= WR_DATA_I;
    end
  end
  // One fetch is answered one cycle after it is seen, then the ack drops.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    if (LINK.fetch_req && !st_r.ack)
    begin
      st_nxt.ack = 1'b1;
      st_nxt.data = mem[LINK.fetch_addr[12:3]];
    end
  end
  // Registers the struct.
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
  assign LINK.fetch_ack = st_r.ack;
  assign LINK.fetch_data = st_r.data;
endmodule

//--- verilog/trw_walker.sv
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
// Overview of operation
// - Translate address first when remapping enabled.
// - Null tile: reads zero, writes dropped.
// - Remapped address goes to page walk.
// - 64KB tiles, 28 index bits 9/9/10.
// - Each level one 4KB page.
// - First-level entry forms address bits 47:16.
// - Second-level base bits 47:12, VA/GPA select.
// - Ignored entry bits have no effect.
// - Bit 1 marks null tile.
// - Bit 0 invalid: zero, drop, interrupt.
// - Software aligns table bases to 4KB.
// - Table sizes 64KB to 512KB allowed.
// - Third-level entry same layout as second.
// - Bypass after reset until software clears.
module trw_walker (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  trw_if.walker LINK,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic REQ_VALID_I,
  input wire logic REQ_WRITE_I,
  input wire logic [47:0] REQ_ADDR_I,
  output logic REQ_READY_O,
  output logic RSP_VALID_O,
  output logic [47:0] RSP_ADDR_O,
  output logic [1:0] RSP_RESULT_O,
  output logic RSP_ZERO_DATA_O,
  output logic RSP_DROP_WRITE_O,
  output logic IRQ_O
);
  typedef enum logic [1:0] {
    TRW_IDLE = 2'b00,
    TRW_FETCH = 2'b01,
    TRW_DONE = 2'b10
  } trw_state_e;
  // Every flip-flop of the walker lives in this struct.
  typedef struct packed {
    trw_state_e state;
    logic [1:0] level;
    logic [47:0] va;
    logic wr;
    logic [47:0] base;
    logic [47:0] rsp_addr;
    logic [1:0] rsp_res;
    logic rsp_wr;
    logic [31:0] ctrl;
    logic [47:0] l3_base;
    logic [1:0] status;
    logic [1:0] mask;
    logic [31:0] rdata;
    logic rd_done;
  } trw_walk_s;
  trw_walk_s st_r;
  trw_walk_s st_nxt;
  logic [63:0] ent; // Fetched entry.
  logic [31:0] l1_ent; // First-level entry: one half of the fetched word.
  logic bus_wr; // Write taken this cycle.
  logic [1:0] ev; // Status events raised this cycle.
  // Walker and register logic; reads answer one cycle late, writes at once.
  always_comb
  begin
    st_nxt = st_r;
    ent = LINK.fetch_data;
    // Two 32-bit first-level entries share each fetched word; index bit 0 picks the half.
    l1_ent = st_r.va[trw_pkg::L1_IDX_LO] ? ent[63:32] : ent[31:0];
    ev = 2'b00;
    bus_wr = AVS_WRITE_I;
    st_nxt.rd_done = AVS_READ_I && !st_r.rd_done;
    if (AVS_READ_I && !st_r.rd_done)
    begin
      // Unmapped offsets read as zero.
      unique case (AVS_ADDRESS_I)
        trw_pkg::REG_CTRL: st_nxt.rdata = st_r.ctrl;
        trw_pkg::REG_L3_LO: st_nxt.rdata = st_r.l3_base[31:0];
        trw_pkg::REG_L3_HI: st_nxt.rdata = {16'h0000, st_r.l3_base[47:32]};
        trw_pkg::REG_STAT: st_nxt.rdata = {14'h0000, st_r.mask, 14'h0000, st_r.status};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    unique case (st_r.state)
      TRW_IDLE:
      begin
        if (REQ_VALID_I)
        begin
          st_nxt.va = REQ_ADDR_I;
          st_nxt.wr = REQ_WRITE_I;
          if (st_r.ctrl[trw_pkg::CTRL_BYPASS])
          begin
            st_nxt.rsp_addr = REQ_ADDR_I;
            st_nxt.rsp_res = trw_pkg::TRW_RES_REMAP;
            st_nxt.rsp_wr = REQ_WRITE_I;
            st_nxt.state = TRW_DONE;
          end
          else
          begin
            st_nxt.level = trw_pkg::FETCH_L3;
            st_nxt.base = st_r.l3_base;
            st_nxt.state = TRW_FETCH;
          end
        end
      end
      TRW_FETCH:
      begin
        if (LINK.fetch_ack)
        begin
          if (st_r.level == trw_pkg::FETCH_L1)
          begin
            // Entry supplies bits 47:16; tile offset kept as is.
            st_nxt.rsp_addr = {l1_ent, st_r.va[15:0]};
            st_nxt.rsp_res = trw_pkg::TRW_RES_REMAP;
            st_nxt.rsp_wr = st_r.wr;
            st_nxt.state = TRW_DONE;
          end
          else if (ent[trw_pkg::INV_BIT])
          begin
            st_nxt.rsp_addr = 48'h0000_0000_0000;
            st_nxt.rsp_res = trw_pkg::TRW_RES_INVALID;
            st_nxt.rsp_wr = st_r.wr;
            ev[trw_pkg::ST_INV] = 1'b1;
            st_nxt.state = TRW_DONE;
          end
          else if (ent[trw_pkg::NULL_BIT])
          begin
            st_nxt.rsp_addr = 48'h0000_0000_0000;
            st_nxt.rsp_res = trw_pkg::TRW_RES_NULL;
            st_nxt.rsp_wr = st_r.wr;
            ev[trw_pkg::ST_NULL] = 1'b1;
            st_nxt.state = TRW_DONE;
          end
          else
          begin
            // Only bits 47:12 are used; 63:48 and 11:2 are ignored.
            st_nxt.base = {ent[47:12], 12'h000};
            st_nxt.level = st_r.level + 2'b01;
          end
        end
      end
      TRW_DONE:
      begin
        st_nxt.state = TRW_IDLE;
      end
      default:
      begin
        st_nxt.state = TRW_IDLE;
      end
    endcase
    if (bus_wr)
    begin
      unique case (AVS_ADDRESS_I)
        trw_pkg::REG_CTRL: st_nxt.ctrl = AVS_WRITEDATA_I;
        trw_pkg::REG_L3_LO: st_nxt.l3_base[31:12] = AVS_WRITEDATA_I[31:12];
        trw_pkg::REG_L3_HI: st_nxt.l3_base[47:32] = AVS_WRITEDATA_I[15:0];
        trw_pkg::REG_STAT:
        begin
          st_nxt.mask = AVS_WRITEDATA_I[17:16];
          st_nxt.status = st_r.status & ~AVS_WRITEDATA_I[1:0];
        end
        default: st_nxt.ctrl = st_r.ctrl;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    st_nxt.status = st_nxt.status | ev;
  end
  // Registers the struct; bypass is on after reset.
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      st_r <= '0;
      st_r.ctrl <= trw_pkg::CTRL_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
  // Fetch address: base plus index scaled by entry size, within one page.
  always_comb
  begin
    unique case (st_r.level)
      trw_pkg::FETCH_L3: LINK.fetch_addr = st_r.base | {36'h0, st_r.va[43:35], 3'h0};
      trw_pkg::FETCH_L2: LINK.fetch_addr = st_r.base | {36'h0, st_r.va[34:26], 3'h0};
      default: LINK.fetch_addr = st_r.base | {36'h0, st_r.va[25:16], 2'h0};
    endcase
  end
  assign LINK.fetch_req = (st_r.state == TRW_FETCH) && !LINK.fetch_ack;
  assign LINK.fetch_kind = st_r.level;
  assign LINK.fetch_gpa = st_r.ctrl[trw_pkg::CTRL_GPA_MODE];
  assign AVS_WAITREQUEST_O = AVS_READ_I && !st_r.rd_done;
  assign AVS_READDATA_O = st_r.rdata;
  assign REQ_READY_O = (st_r.state == TRW_IDLE);
  assign RSP_VALID_O = (st_r.state == TRW_DONE);
  assign RSP_ADDR_O = st_r.rsp_addr;
  assign RSP_RESULT_O = st_r.rsp_res;
  // Non-remapped results return zero and drop writes.
  assign RSP_ZERO_DATA_O = RSP_VALID_O && (st_r.rsp_res != trw_pkg::TRW_RES_REMAP);
  assign RSP_DROP_WRITE_O = RSP_ZERO_DATA_O && st_r.rsp_wr;
  assign IRQ_O = |(st_r.status & st_r.mask);
endmodule
